//--- src/acfg_pkg.sv
// Constants shared by the acceleration sensor configuration register bank.
// Assumes byte-wide register access with eight-bit addresses.
package acfg_pkg;

	// ----------------------------------------------------------------
	// Direct register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] ACFG_OFF_REVISION = 8'h00;
	localparam logic [7:0] ACFG_OFF_STATUS = 8'h02;
	localparam logic [7:0] ACFG_OFF_MODE = 8'h14;
	localparam logic [7:0] ACFG_OFF_RD_POINTER = 8'h17;
	localparam logic [7:0] ACFG_OFF_SELECTOR = 8'h18;
	localparam logic [7:0] ACFG_OFF_CTRL_DATA = 8'h19;

	// ----------------------------------------------------------------
	// Identity values (arbitrary neutral values)
	// ----------------------------------------------------------------
	localparam logic [3:0] ACFG_MAJOR_REVISION = 4'h0;
	localparam logic [3:0] ACFG_MINOR_REVISION = 4'h0;

	// ----------------------------------------------------------------
	// Status bit positions
	// ----------------------------------------------------------------
	localparam int ACFG_ST_LOCK = 5;
	localparam int ACFG_ST_CHECKSUM = 1;
	localparam int ACFG_ST_FRAME = 0;

	// ----------------------------------------------------------------
	// Mode register layout
	// ----------------------------------------------------------------
	localparam int ACFG_MD_BUF_EN = 7;
	localparam int ACFG_MD_BYTE_FMT = 6;
	localparam int ACFG_MD_FREEFALL = 4;
	localparam logic [7:0] ACFG_MODE_MASK = 8'hd7;
	localparam logic [7:0] ACFG_MODE_RESET = 8'h00;
	localparam logic [2:0] ACFG_OP_NORMAL = 3'h0;
	localparam logic [2:0] ACFG_OP_OPTION1 = 3'h2;
	localparam logic [2:0] ACFG_OP_OPTION2 = 3'h1;
	localparam logic [2:0] ACFG_OP_MOTION = 3'h3;

	// ----------------------------------------------------------------
	// Indirect register selector codes and layouts
	// ----------------------------------------------------------------
	localparam logic [4:0] ACFG_SEL_RESET = 5'h00;
	localparam logic [4:0] ACFG_SEL_I2C_DIS = 5'h01;
	localparam logic [4:0] ACFG_SEL_COMBINE = 5'h02;
	localparam logic [4:0] ACFG_SEL_THR_Y = 5'h03;
	localparam logic [4:0] ACFG_SEL_THR_X = 5'h04;
	localparam logic [4:0] ACFG_SEL_THR_Z = 5'h05;
	localparam logic [4:0] ACFG_SEL_OUT_CTRL = 5'h0b;
	localparam logic [7:0] ACFG_COMBINE_MASK = 8'h3f;
	localparam logic [7:0] ACFG_COMBINE_RESET = 8'h07;
	localparam logic [7:0] ACFG_OUT_CTRL_MASK = 8'h1f;
	localparam logic [7:0] ACFG_OUT_CTRL_RESET = 8'h00;
	localparam logic [7:0] ACFG_I2C_DIS_RESET = 8'h00;
	localparam logic [7:0] ACFG_THRESHOLD_RESET = 8'h10;
	localparam int ACFG_CB_REQ_Z = 5;
	localparam int ACFG_CB_REQ_X = 4;
	localparam int ACFG_CB_REQ_Y = 3;
	localparam int ACFG_CB_EN_Z = 2;
	localparam int ACFG_CB_EN_X = 1;
	localparam int ACFG_CB_EN_Y = 0;

	// ----------------------------------------------------------------
	// Motion flag positions in the reported axis flags
	// ----------------------------------------------------------------
	localparam int ACFG_MF_Y = 2;
	localparam int ACFG_MF_X = 1;
	localparam int ACFG_MF_Z = 0;

endpackage

//--- src/acfg_register_bank.sv
// Configuration register bank of a three-axis acceleration sensor.
// Assumes a byte-wide register port driven synchronously by the serial front end,
// and absolute per-axis magnitudes presented with a one-cycle valid strobe.
`timescale 1ns/1ps
module acfg_register_bank
	import acfg_pkg::*;
#(
	parameter logic [7:0] THRESHOLD_RESET = ACFG_THRESHOLD_RESET
) (
	input wire logic ref_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] reg_addr_in,
	input wire logic reg_wr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic reg_rd_in,
	output logic [7:0] reg_rdata_out,
	input wire logic lock_open_in,
	input wire logic checksum_fail_in,
	input wire logic frame_error_in,
	input wire logic frame_good_in,
	input wire logic sample_valid_in,
	input wire logic [7:0] mag_x_in,
	input wire logic [7:0] mag_y_in,
	input wire logic [7:0] mag_z_in,
	input wire logic buf_load_in,
	input wire logic [10:0] buf_sample_in,
	output logic [7:0] buf_frame_first_out,
	output logic [7:0] buf_frame_second_out,
	output logic buf_two_frames_out,
	output logic buffer_enable_out,
	output logic freefall_enable_out,
	output logic [2:0] op_mode_out,
	output logic [7:0] i2c_read_pointer_out,
	output logic [7:0] i2c_disable_out,
	output logic [7:0] output_control_out,
	output logic motion_event_out,
	output logic [2:0] motion_flags_out
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic lock_r;
	logic checksum_r;
	logic frame_err_r;
	logic [7:0] mode_r;
	logic [4:0] sel_r;
	logic [7:0] combine_r;
	logic [7:0] thr_r [0:2];
	logic [7:0] mag [0:2];
	logic [2:0] trig;
	logic motion_nxt;
	logic [7:0] fmt_first;
	logic [7:0] fmt_second;
	logic fmt_two;
	logic wr_mode;
	logic wr_sel;
	logic wr_data;

	assign wr_mode = reg_wr_in && (reg_addr_in == ACFG_OFF_MODE);
	assign wr_sel = reg_wr_in && (reg_addr_in == ACFG_OFF_SELECTOR);
	assign wr_data = reg_wr_in && (reg_addr_in == ACFG_OFF_CTRL_DATA);

	// Index 0 is Y, 1 is X, 2 is Z, matching the selector code order.
	assign mag[0] = mag_y_in;
	assign mag[1] = mag_x_in;
	assign mag[2] = mag_z_in;

	// Maps a selector code to a threshold slot, or 3 when it is no threshold.
	function automatic logic [1:0] thr_slot(input logic [4:0] code);
		if (code == ACFG_SEL_THR_Y) begin
			thr_slot = 2'd0;
		end else if (code == ACFG_SEL_THR_X) begin
			thr_slot = 2'd1;
		end else if (code == ACFG_SEL_THR_Z) begin
			thr_slot = 2'd2;
		end else begin
			thr_slot = 2'd3;
		end
	endfunction

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	// Lock and checksum are sampled every cycle so reads see settled levels.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			lock_r <= 1'b0;
			checksum_r <= 1'b0;
		end else begin
			lock_r <= lock_open_in;
			checksum_r <= checksum_fail_in;
		end
	end

	// A bad frame in the same cycle as a good one wins, so no error is lost.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			frame_err_r <= 1'b0;
		end else if (frame_error_in) begin
			frame_err_r <= 1'b1;
		end else if (frame_good_in) begin
			frame_err_r <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Direct configuration registers
	// ----------------------------------------------------------------
	// Reserved mode bits are masked so they never store a value.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mode_r <= ACFG_MODE_RESET;
		end else if (wr_mode) begin
			mode_r <= reg_wdata_in & ACFG_MODE_MASK;
		end
	end

	// Reserved mode codes are stored as written; the host must avoid them.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			buffer_enable_out <= 1'b0;
			freefall_enable_out <= 1'b0;
			op_mode_out <= ACFG_OP_NORMAL;
		end else begin
			buffer_enable_out <= mode_r[ACFG_MD_BUF_EN];
			freefall_enable_out <= mode_r[ACFG_MD_FREEFALL];
			op_mode_out <= mode_r[2:0];
		end
	end

	// The read pointer is write-only and only consumed by the I2C reader.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			i2c_read_pointer_out <= 8'h00;
		end else if (reg_wr_in && (reg_addr_in == ACFG_OFF_RD_POINTER)) begin
			i2c_read_pointer_out <= reg_wdata_in;
		end
	end

	// Selector writes only land while the lock is open.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			sel_r <= ACFG_SEL_RESET;
		end else if (wr_sel && lock_r) begin
			sel_r <= reg_wdata_in[4:0];
		end
	end

	// ----------------------------------------------------------------
	// Indirect registers behind the control-data window
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			combine_r <= ACFG_COMBINE_RESET;
			i2c_disable_out <= ACFG_I2C_DIS_RESET;
			output_control_out <= ACFG_OUT_CTRL_RESET;
		end else if (wr_data) begin
			if (sel_r == ACFG_SEL_COMBINE) begin
				combine_r <= reg_wdata_in & ACFG_COMBINE_MASK;
			end else if (sel_r == ACFG_SEL_I2C_DIS) begin
				i2c_disable_out <= reg_wdata_in;
			end else if (sel_r == ACFG_SEL_OUT_CTRL) begin
				output_control_out <= reg_wdata_in & ACFG_OUT_CTRL_MASK;
			end
		end
	end

	// One threshold register per axis; writes to reserved codes fall through.
	generate
		for (genvar i = 0; i < 3; i++) begin : g_thr
			always_ff @(posedge ref_clk_in or posedge rst_in) begin
				if (rst_in) begin
					thr_r[i] <= THRESHOLD_RESET;
				end else if (wr_data && (thr_slot(sel_r) == 2'(i))) begin
					thr_r[i] <= reg_wdata_in;
				end
			end
			assign trig[i] = mag[i] > thr_r[i];
		end
	endgenerate

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	// Unmapped and write-only addresses read zero rather than stale data.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= 8'h00;
		end else if (reg_rd_in) begin
			if (reg_addr_in == ACFG_OFF_REVISION) begin
				reg_rdata_out <= {ACFG_MAJOR_REVISION, ACFG_MINOR_REVISION};
			end else if (reg_addr_in == ACFG_OFF_STATUS) begin
				reg_rdata_out <= {2'h0, lock_r, 3'h0, checksum_r, frame_err_r};
			end else if (reg_addr_in == ACFG_OFF_MODE) begin
				reg_rdata_out <= mode_r;
			end else if (reg_addr_in == ACFG_OFF_SELECTOR) begin
				reg_rdata_out <= {3'h0, sel_r};
			end else if (reg_addr_in == ACFG_OFF_CTRL_DATA) begin
				if (sel_r == ACFG_SEL_COMBINE) begin
					reg_rdata_out <= combine_r;
				end else if (sel_r == ACFG_SEL_I2C_DIS) begin
					reg_rdata_out <= i2c_disable_out;
				end else if (sel_r == ACFG_SEL_OUT_CTRL) begin
					reg_rdata_out <= output_control_out;
				end else if (thr_slot(sel_r) != 2'd3) begin
					reg_rdata_out <= thr_r[thr_slot(sel_r)];
				end else begin
					reg_rdata_out <= 8'h00;
				end
			end else begin
				reg_rdata_out <= 8'h00;
			end
		end
	end

	// ----------------------------------------------------------------
	// Motion detector channel combination
	// ----------------------------------------------------------------
	// Combination bits are ordered Z X Y, so index 2..0 lines up with trig.
	assign motion_nxt = (op_mode_out == ACFG_OP_MOTION) && sample_valid_in
		&& ((trig & combine_r[2:0]) != 3'h0)
		&& ((combine_r[5:3] & ~{trig[2], trig[1], trig[0]}) == 3'h0);

	// Flags hold the last detection's axes until the next detection.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			motion_event_out <= 1'b0;
			motion_flags_out <= 3'h0;
		end else begin
			motion_event_out <= motion_nxt;
			if (motion_nxt) begin
				motion_flags_out[ACFG_MF_Y] <= trig[0];
				motion_flags_out[ACFG_MF_X] <= trig[1];
				motion_flags_out[ACFG_MF_Z] <= trig[2];
			end
		end
	end

	// ----------------------------------------------------------------
	// Buffer sample framing
	// ----------------------------------------------------------------
	acfg_sample_format u_format (
		.sample_in(buf_sample_in),
		.byte_mode_in(mode_r[ACFG_MD_BYTE_FMT]),
		.frame_first_out(fmt_first),
		.frame_second_out(fmt_second),
		.two_frames_out(fmt_two)
	);

	// Frames only refresh while the buffer is powered.
	always_ff @(posedge ref_clk_in or posedge rst_in) begin
		if (rst_in) begin
			buf_frame_first_out <= 8'h00;
			buf_frame_second_out <= 8'h00;
			buf_two_frames_out <= 1'b0;
		end else if (buf_load_in && mode_r[ACFG_MD_BUF_EN]) begin
			buf_frame_first_out <= fmt_first;
			buf_frame_second_out <= fmt_second;
			buf_two_frames_out <= fmt_two;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);

	sequence s_status_read;
		reg_rd_in && reg_addr_in == ACFG_OFF_STATUS;
	endsequence

	status_lock_a: assert property (lock_open_in ##1 s_status_read |=> reg_rdata_out[5])
		else $error("lock bit not reported");
	checksum_bit_a: assert property (checksum_fail_in ##1 s_status_read |=> reg_rdata_out[1])
		else $error("checksum bit not reported");
	frame_set_a: assert property (frame_error_in ##1 s_status_read |=> reg_rdata_out[0])
		else $error("frame error not reported");
	frame_clear_a: assert property (frame_good_in && !frame_error_in |=> !frame_err_r)
		else $error("frame error not cleared");
	buf_enable_a: assert property (wr_mode |=> ##1 buffer_enable_out == $past(reg_wdata_in[7], 2))
		else $error("buffer enable wrong");
	freefall_en_a: assert property (wr_mode |=> ##1 freefall_enable_out == $past(reg_wdata_in[4], 2))
		else $error("free-fall enable wrong");
	byte_frame_a: assert property (buf_load_in && mode_r[7] && mode_r[6] |=> !buf_two_frames_out)
		else $error("byte mode gave two frames");
	word_frame_a: assert property (buf_load_in && mode_r[7] && !mode_r[6]
		|=> buf_two_frames_out && buf_frame_second_out[4:0] == 5'h00)
		else $error("11-bit frames wrong");
	sel_locked_a: assert property (wr_sel && !lock_r |=> $stable(sel_r))
		else $error("locked selector changed");
	sel_write_a: assert property (wr_sel && lock_r |=> sel_r == $past(reg_wdata_in[4:0]))
		else $error("selector write lost");
	revision_read_a: assert property (reg_rd_in && reg_addr_in == ACFG_OFF_REVISION
		|=> reg_rdata_out == {ACFG_MAJOR_REVISION, ACFG_MINOR_REVISION})
		else $error("revision wrong");
	mode_reserved_a: assert property (reg_rd_in && reg_addr_in == ACFG_OFF_MODE
		|=> reg_rdata_out[5] == 1'b0 && reg_rdata_out[3] == 1'b0)
		else $error("reserved mode bit set");
	motion_needs_a: assert property (motion_event_out |-> $past(op_mode_out) == ACFG_OP_MOTION
		&& ($past(combine_r[5:3]) & ~$past(trig)) == 3'h0)
		else $error("motion without required axes");
	motion_off_a: assert property (sample_valid_in && (trig & combine_r[2:0]) == 3'h0
		|=> !motion_event_out)
		else $error("motion without enabled trigger");

endmodule

//--- src/acfg_sample_format.sv
// Splits one stored axis sample into output frames.
// Assumes the sample is sign plus ten magnitude bits, sign in bit 10.
`timescale 1ns/1ps
module acfg_sample_format
	import acfg_pkg::*;
(
	input wire logic [10:0] sample_in,
	input wire logic byte_mode_in,
	output logic [7:0] frame_first_out,
	output logic [7:0] frame_second_out,
	output logic two_frames_out
);

	// In byte mode only sign and the seven upper bits survive; the second frame is unused.
	always_comb begin
		if (byte_mode_in) begin
			frame_first_out = sample_in[10:3];
			frame_second_out = 8'h00;
			two_frames_out = 1'b0;
		end else begin
			frame_first_out = sample_in[10:3];
			frame_second_out = {sample_in[2:0], 5'h00};
			two_frames_out = 1'b1;
		end
	end

endmodule

//--- verification/accel_config_register_bank_tb.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the register port; this module drives the rest.
`timescale 1ns/1ps
module accel_config_register_bank_tb;
	import acfg_pkg::*;
	localparam logic [7:0] THR_RST = 8'h10;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [7:0] reg_addr, reg_wdata, reg_rdata_out, mag_x_in, mag_y_in, mag_z_in;
	logic reg_wr, reg_rd, lock_open_in, checksum_fail_in, frame_error_in, frame_good_in;
	logic sample_valid_in, buf_load_in, buf_two_frames_out, buffer_enable_out, freefall_enable_out;
	logic motion_event_out;
	logic [10:0] buf_sample_in;
	logic [7:0] buf_frame_first_out, buf_frame_second_out, i2c_read_pointer_out, i2c_disable_out;
	logic [7:0] output_control_out, thr_x, thr_y, thr_z;
	logic [2:0] op_mode_out, motion_flags_out;
	logic [5:0] cb_v;
	logic [4:0] ind_code [6] = '{ACFG_SEL_I2C_DIS, ACFG_SEL_COMBINE, ACFG_SEL_THR_Y, ACFG_SEL_THR_X,
		ACFG_SEL_THR_Z, ACFG_SEL_OUT_CTRL};
	logic [7:0] ind_mask [6] = '{8'hff, ACFG_COMBINE_MASK, 8'hff, 8'hff, 8'hff, ACFG_OUT_CTRL_MASK};
	logic [7:0] ind_rst [6] = '{ACFG_I2C_DIS_RESET, ACFG_COMBINE_RESET, THR_RST, THR_RST, THR_RST,
		ACFG_OUT_CTRL_RESET};
	logic [2:0] op_codes [4] = '{ACFG_OP_NORMAL, ACFG_OP_OPTION1, ACFG_OP_OPTION2, ACFG_OP_MOTION};
	int error_cnt = 0;
	int checked = 0;
	int cycles = 0;

	// ----------------------------------------------------------------
	// Clock, instances and watchdog
	// ----------------------------------------------------------------
	// Free running 250 MHz clock.
	always #2 ref_clk_in = ~ref_clk_in;

	acfg_register_bank #(.THRESHOLD_RESET(THR_RST)) u_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
		.reg_addr_in(reg_addr), .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
		.reg_rdata_out(reg_rdata_out), .lock_open_in(lock_open_in), .checksum_fail_in(checksum_fail_in),
		.frame_error_in(frame_error_in), .frame_good_in(frame_good_in), .sample_valid_in(sample_valid_in),
		.mag_x_in(mag_x_in), .mag_y_in(mag_y_in), .mag_z_in(mag_z_in), .buf_load_in(buf_load_in),
		.buf_sample_in(buf_sample_in), .buf_frame_first_out(buf_frame_first_out),
		.buf_frame_second_out(buf_frame_second_out), .buf_two_frames_out(buf_two_frames_out),
		.buffer_enable_out(buffer_enable_out), .freefall_enable_out(freefall_enable_out),
		.op_mode_out(op_mode_out), .i2c_read_pointer_out(i2c_read_pointer_out),
		.i2c_disable_out(i2c_disable_out), .output_control_out(output_control_out),
		.motion_event_out(motion_event_out), .motion_flags_out(motion_flags_out));

	acfg_host_model u_host (.clk_in(ref_clk_in), .rdata_in(reg_rdata_out), .addr_out(reg_addr),
		.wr_out(reg_wr), .wdata_out(reg_wdata), .rd_out(reg_rd));

	// The whole run needs under a thousand cycles; a hang is cut off well beyond that.
	always @(posedge ref_clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (error_cnt == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Returns detection in bit 3 and axis flags Y, X, Z in bits 2:0.
	function automatic logic [3:0] motion_exp(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z);
		logic [2:0] trig;
		logic det;
		trig = {z > thr_z, x > thr_x, y > thr_y};
		det = (|(trig & cb_v[2:0])) && ((trig & cb_v[5:3]) == cb_v[5:3]);
		return {det, trig[0], trig[1], trig[2]};
	endfunction

	// Values close to a threshold hit the strict comparison boundary.
	function automatic logic [7:0] near(input logic [7:0] t);
		if ($urandom_range(3) == 0) begin
			return 8'($urandom);
		end
		return t + 8'($urandom_range(2)) - 8'h01;
	endfunction

	task automatic set_ind(input logic [4:0] code, input logic [7:0] v);
		u_host.write_reg(ACFG_OFF_SELECTOR, {3'h0, code});
		u_host.write_reg(ACFG_OFF_CTRL_DATA, v);
	endtask

	task automatic set_motion(input logic [5:0] cb);
		cb_v = cb;
		thr_x = 8'($urandom);
		thr_y = 8'($urandom);
		thr_z = 8'($urandom);
		set_ind(ACFG_SEL_COMBINE, {2'h0, cb});
		set_ind(ACFG_SEL_THR_Y, thr_y);
		set_ind(ACFG_SEL_THR_X, thr_x);
		set_ind(ACFG_SEL_THR_Z, thr_z);
	endtask

	// One sample; the pulse is counted over three cycles so its exact slot does not matter.
	task automatic motion_try(input logic armed);
		logic [3:0] e;
		logic [2:0] f;
		int n;
		@(posedge ref_clk_in);
		mag_x_in <= near(thr_x);
		mag_y_in <= near(thr_y);
		mag_z_in <= near(thr_z);
		sample_valid_in <= 1'b1;
		@(posedge ref_clk_in);
		sample_valid_in <= 1'b0;
		e = motion_exp(mag_x_in, mag_y_in, mag_z_in);
		n = 0;
		f = 3'h0;
		repeat (3) begin
			#1;
			if (motion_event_out === 1'b1) begin
				n++;
				f = motion_flags_out;
			end
			@(posedge ref_clk_in);
		end
		check(8'(n), {7'h0, e[3] & armed});
		if (e[3] & armed) begin
			check({5'h0, f}, {5'h0, e[2:0]});
		end
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [7:0] d, m, dis_v, oc_v;
		logic [10:0] s;
		{lock_open_in, checksum_fail_in, frame_error_in, frame_good_in, sample_valid_in, buf_load_in} = 6'h00;
		{mag_x_in, mag_y_in, mag_z_in, buf_sample_in} = 35'h0;
		void'($urandom(10));
		repeat (5) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		u_host.read_reg(ACFG_OFF_REVISION, d);
		check(d, {ACFG_MAJOR_REVISION, ACFG_MINOR_REVISION});
		u_host.write_reg(ACFG_OFF_REVISION, 8'hff);
		u_host.read_reg(ACFG_OFF_REVISION, d);
		check(d, {ACFG_MAJOR_REVISION, ACFG_MINOR_REVISION});
		u_host.read_reg(ACFG_OFF_STATUS, d);
		check(d, 8'h00);
		u_host.read_reg(ACFG_OFF_MODE, d);
		check(d, ACFG_MODE_RESET);
		u_host.read_reg(8'h7f, d);
		check(d, 8'h00);
		check({3'h0, buffer_enable_out, freefall_enable_out, op_mode_out}, 8'h00);
		// Selector writes are dropped while the lock is closed.
		u_host.write_reg(ACFG_OFF_SELECTOR, 8'h02);
		u_host.read_reg(ACFG_OFF_SELECTOR, d);
		check(d, 8'h00);
		@(posedge ref_clk_in);
		lock_open_in <= 1'b1;
		checksum_fail_in <= 1'b1;
		frame_error_in <= 1'b1;
		@(posedge ref_clk_in);
		// The error pulse ends as the read is presented, so the read follows it directly.
		fork
			u_host.read_reg(ACFG_OFF_STATUS, d);
			begin
				@(posedge ref_clk_in);
				frame_error_in <= 1'b0;
			end
		join
		check(d, 8'h23);
		@(posedge ref_clk_in);
		frame_good_in <= 1'b1;
		checksum_fail_in <= 1'b0;
		@(posedge ref_clk_in);
		frame_good_in <= 1'b0;
		u_host.read_reg(ACFG_OFF_STATUS, d);
		check(d, 8'h20);
		// Every listed operation code, with random values in the other bits.
		for (int i = 0; i < 4; i++) begin
			m = (8'($urandom) & 8'hf8) | {5'h0, op_codes[i]};
			u_host.write_reg(ACFG_OFF_MODE, m);
			repeat (2) @(posedge ref_clk_in);
			#1;
			check({7'h0, buffer_enable_out}, {7'h0, m[7]});
			check({7'h0, freefall_enable_out}, {7'h0, m[4]});
			check({5'h0, op_mode_out}, {5'h0, op_codes[i]});
			u_host.read_reg(ACFG_OFF_MODE, d);
			check(d, m & ACFG_MODE_MASK);
		end
		d = 8'($urandom);
		u_host.write_reg(ACFG_OFF_RD_POINTER, d);
		repeat (2) @(posedge ref_clk_in);
		check(i2c_read_pointer_out, d);
		u_host.i2c_read(ACFG_OFF_MODE, d);
		check(d, m & ACFG_MODE_MASK);
		u_host.read_reg(ACFG_OFF_RD_POINTER, d);
		check(d, 8'h00);
		// Indirect registers: reset value, then masked write and read back.
		for (int i = 0; i < 6; i++) begin
			u_host.write_reg(ACFG_OFF_SELECTOR, {3'h7, ind_code[i]});
			u_host.read_reg(ACFG_OFF_SELECTOR, d);
			check(d, {3'h0, ind_code[i]});
			u_host.read_reg(ACFG_OFF_CTRL_DATA, d);
			check(d, ind_rst[i]);
			m = 8'($urandom);
			u_host.write_reg(ACFG_OFF_CTRL_DATA, m);
			u_host.read_reg(ACFG_OFF_CTRL_DATA, d);
			check(d, m & ind_mask[i]);
			if (i == 0) dis_v = m;
			if (i == 5) oc_v = m & ACFG_OUT_CTRL_MASK;
		end
		check(i2c_disable_out, dis_v);
		check(output_control_out, oc_v);
		// Framing in both formats, then a load with the buffer off must change nothing.
		for (int b = 0; b < 3; b++) begin
			u_host.write_reg(ACFG_OFF_MODE, {b < 2, b == 1, 6'h03});
			repeat (6) begin
				s = 11'($urandom);
				@(posedge ref_clk_in);
				buf_sample_in <= s;
				buf_load_in <= 1'b1;
				@(posedge ref_clk_in);
				buf_load_in <= 1'b0;
				@(posedge ref_clk_in);
				#1;
				if (b < 2) begin
					m = (b == 1) ? 8'h00 : {s[2:0], 5'h00};
					check(buf_frame_first_out, s[10:3]);
					check(buf_frame_second_out, m);
					check({7'h0, buf_two_frames_out}, {7'h0, b == 0});
					d = s[10:3];
				end else begin
					// The last accepted load was a byte-mode one, so its frames must still stand.
					check(buf_frame_second_out, 8'h00);
					check(buf_frame_first_out, d);
					check({7'h0, buf_two_frames_out}, 8'h00);
				end
			end
		end
		// Motion detection: documented combinations first, then random ones.
		u_host.write_reg(ACFG_OFF_MODE, {5'h0, ACFG_OP_MOTION});
		for (int k = 0; k < 8; k++) begin
			set_motion(k == 0 ? 6'h1b : (k == 1 ? 6'h03 : 6'($urandom)));
			repeat (10) motion_try(1'b1);
		end
		u_host.write_reg(ACFG_OFF_MODE, {5'h0, ACFG_OP_NORMAL});
		repeat (2) @(posedge ref_clk_in);
		repeat (5) motion_try(1'b0);
		test_done();
	end
endmodule

//--- verification/acfg_host_model.sv
// Host controller model for the register port: byte writes and reads.
// Assumes the bench calls its tasks from one process, one transfer at a time.
`timescale 1ns/1ps
module acfg_host_model
	import acfg_pkg::*;
(
	input wire logic clk_in,
	input wire logic [7:0] rdata_in,
	output logic [7:0] addr_out,
	output logic wr_out,
	output logic [7:0] wdata_out,
	output logic rd_out
);
	// ----------------------------------------------------------------
	// Bus transfers
	// ----------------------------------------------------------------
	// Idle values before the first request.
	initial begin
		addr_out = 8'h00;
		wr_out = 1'b0;
		wdata_out = 8'h00;
		rd_out = 1'b0;
	end

	// Address and data go to their inverse once the strobe drops, so stale values never help.
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		wdata_out <= d;
		wr_out <= 1'b1;
		@(posedge clk_in);
		wr_out <= 1'b0;
		addr_out <= ~a;
		wdata_out <= ~d;
	endtask

	// Data is taken one full cycle after the taking edge; it holds until the next read.
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		addr_out <= a;
		rd_out <= 1'b1;
		@(posedge clk_in);
		rd_out <= 1'b0;
		addr_out <= ~a;
		@(posedge clk_in);
		#1;
		d = rdata_in;
	endtask

	// The pointer is loaded first, as a two-wire read must name its target.
	task automatic i2c_read(input logic [7:0] a, output logic [7:0] d);
		write_reg(ACFG_OFF_RD_POINTER, a);
		read_reg(a, d);
	endtask
endmodule
